// file: hw/est_engine.sv
// metering engine end: adc samples in, period results out, mailbox to host
// assumes adc pins are asynchronous and a sample is marked by a rising adc_valid
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
module est_engine (
  input wire logic pclk,
  input wire logic presetn,
  est_mbox_if.engine mb,
  input wire logic adc_valid,
  input wire logic [15:0] adc_v,
  input wire logic [15:0] adc_i1,
  input wire logic [15:0] adc_i2,
  output logic [47:0] active_energy_result,
  output logic [47:0] energy_total,
  output logic [15:0] power_factor_result,
  output logic [15:0] engine_status_word
);
  // widened before the product, a 16-bit product would lose the square
  function automatic logic [31:0] sq16(input logic [15:0] x);
    logic signed [31:0] xs;
    xs = 32'($signed(x));
    sq16 = xs * xs;
  endfunction

  // second current only counts with both channels in use
  function automatic logic use_i2_next(input logic two, input logic [43:0] s1, input logic [43:0] s2);
    use_i2_next = two && (s1 < s2);
  endfunction

  logic [2:0] vld_sync;
  logic [47:0] dat_s1;
  logic [47:0] dat_s2;
  logic sample_stb;
  logic [15:0] engine_control_word;
  logic [15:0] first_current_adapt_factor;
  logic [15:0] second_current_adapt_factor;
  logic [15:0] tamper_ratio;
  logic [15:0] tamper_threshold_current;
  logic [11:0] sample_cnt;
  logic period_done;
  logic [43:0] sq1_sum;
  logic [43:0] sq2_sum;
  logic signed [47:0] en_sum;
  logic use_i2;
  logic [15:0] i1_adj;
  logic [15:0] i2_adj;
  logic [15:0] v_s;
  logic two_curr;
  logic [1:0] ne_mode;
  logic evt_pending;
  logic ack_pending;
  logic [15:0] ack_ptr;
  logic [43:0] big_sum;
  logic [43:0] small_sum;
  logic [43:0] thr_sum;
  logic [31:0] ratio_sq;
  logic [75:0] lhs;
  logic [75:0] rhs;
  logic next_tamp;
  logic signed [47:0] en_abs;
  logic sel_i2;

  // pins synchronised; no edge, no progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vld_sync <= 3'h0;
      dat_s1 <= 48'h0;
      dat_s2 <= 48'h0;
    end else begin
      vld_sync <= {vld_sync[1:0], adc_valid};
      dat_s1 <= {adc_v, adc_i1, adc_i2};
      dat_s2 <= dat_s1;
    end
  end
  assign sample_stb = vld_sync[1] & ~vld_sync[2] & mb.engine_en;
  // samples already clipped by the converter
  assign v_s = dat_s2[47:32];
  assign two_curr = engine_control_word[est_pkg::CTL_CURR_I2];
  assign ne_mode = {engine_control_word[est_pkg::CTL_NE_HI], engine_control_word[est_pkg::CTL_NE_LO]};

  est_sat_mul u_mul1 (
    .sample(dat_s2[31:16]),
    .factor(first_current_adapt_factor),
    .result(i1_adj)
  );
  est_sat_mul u_mul2 (
    .sample(dat_s2[15:0]),
    .factor(second_current_adapt_factor),
    .result(i2_adj)
  );

  // parameters written only through the outbound mailbox
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_control_word <= est_pkg::CTRL_RST;
      first_current_adapt_factor <= est_pkg::ADAPT_RST;
      second_current_adapt_factor <= est_pkg::ADAPT_RST;
      tamper_ratio <= est_pkg::RATIO_RST;
      tamper_threshold_current <= est_pkg::TAMPER_THRESHOLD_CURRENT_RST;
      mb.out_ack <= 1'b0;
    end else begin
      mb.out_ack <= mb.out_valid & ~mb.out_ack & ~ack_pending;
      if (mb.out_valid && !mb.out_ack && !ack_pending) begin
        case (mb.out_ptr)
          est_pkg::PTR_CTRL: engine_control_word <= mb.out_data;
          est_pkg::PTR_ADAPT1: first_current_adapt_factor <= mb.out_data;
          est_pkg::PTR_ADAPT2: second_current_adapt_factor <= mb.out_data;
          // host keeps ratio within 1.0 to below 2.0
          est_pkg::PTR_RATIO: tamper_ratio <= mb.out_data;
          est_pkg::PTR_TAMPER_THRESHOLD_CURRENT: tamper_threshold_current <= mb.out_data;
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_cnt <= 12'h000;
      period_done <= 1'b0;
    end else begin
      period_done <= sample_stb && (sample_cnt == est_pkg::PERIOD_LAST);
      if (sample_stb) begin
        sample_cnt <= sample_cnt + 12'h001;
      end
    end
  end

  // energy uses the current found larger last period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq1_sum <= 44'h0;
      sq2_sum <= 44'h0;
      en_sum <= 48'sh0;
    end else begin
      if (period_done || sample_stb) begin
        sq1_sum <= (period_done ? 44'h0 : sq1_sum) + (sample_stb ? {12'h000, sq16(i1_adj)} : 44'h0);
        sq2_sum <= (period_done ? 44'h0 : sq2_sum) + (sample_stb ? {12'h000, sq16(i2_adj)} : 44'h0);
        en_sum <= (period_done ? 48'sh0 : en_sum) +
                  (sample_stb ? 48'($signed(v_s)) * 48'($signed(use_i2 ? i2_adj : i1_adj)) : 48'sh0);
      end
    end
  end

  assign sel_i2 = use_i2_next(two_curr, sq1_sum, sq2_sum);
  assign big_sum = sel_i2 ? sq2_sum : sq1_sum;
  assign small_sum = sel_i2 ? sq1_sum : sq2_sum;
  assign thr_sum = {sq16(tamper_threshold_current), 12'h000};
  assign ratio_sq = {16'h0000, tamper_ratio} * {16'h0000, tamper_ratio};
  // squares compared, so the ratio enters squared
  assign lhs = {4'h0, big_sum, 28'h0};
  assign rhs = {32'h0, small_sum} * {44'h0, ratio_sq};
  assign next_tamp = !(sq1_sum < thr_sum && sq2_sum < thr_sum) && (lhs >= rhs);
  assign en_abs = en_sum[47] ? -en_sum : en_sum;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_i2 <= 1'b0;
      engine_status_word <= 16'h0000;
      active_energy_result <= 48'h0;
      energy_total <= 48'h0;
      power_factor_result <= est_pkg::PF_POS;
    end else if (period_done) begin
      use_i2 <= sel_i2;
      // flag set only when first is smaller
      engine_status_word[est_pkg::ST_I2GT] <= sel_i2;
      engine_status_word[est_pkg::ST_TAMP] <= two_curr && next_tamp;
      engine_status_word[est_pkg::ST_TEMP_I2] <= ~sel_i2;
      engine_status_word[est_pkg::ST_NEG] <= en_sum[47];
      power_factor_result <= est_pkg::PF_POS;
      if (!en_sum[47]) begin
        active_energy_result <= en_sum;
        energy_total <= energy_total + en_sum;
      end else begin
        case (ne_mode)
          est_pkg::NE_SKIP: active_energy_result <= 48'h0;
          est_pkg::NE_ABS: begin
            // negative result kept for the host
            active_energy_result <= en_sum;
            energy_total <= energy_total + en_abs;
          end
          est_pkg::NE_SIGNED: begin
            active_energy_result <= en_sum;
            energy_total <= energy_total + en_sum;
            power_factor_result <= est_pkg::PF_NEG;
          end
          // reserved code treated like skip
          default: active_energy_result <= 48'h0;
        endcase
      end
    end
  end

  // inbound mailbox: event first, parameter acknowledge second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_pending <= 1'b0;
      ack_pending <= 1'b0;
      ack_ptr <= 16'h0000;
      mb.in_valid <= 1'b0;
      mb.in_first <= 16'h0000;
      mb.in_second <= 16'h0000;
    end else begin
      if (mb.in_valid && mb.in_ack) begin
        mb.in_valid <= 1'b0;
      end else if (!mb.in_valid && evt_pending && !period_done) begin
        mb.in_valid <= 1'b1;
        mb.in_first <= est_pkg::RET_EVENT;
        mb.in_second <= engine_status_word;
      end else if (!mb.in_valid && ack_pending) begin
        mb.in_valid <= 1'b1;
        mb.in_first <= est_pkg::RET_PARAM_SET;
        mb.in_second <= ack_ptr;
      end
      // set wins over the clear
      if (period_done && engine_control_word[est_pkg::CTL_EVT_EN]) begin
        evt_pending <= 1'b1;
      end else if (!mb.in_valid && !period_done) begin
        evt_pending <= 1'b0;
      end
      if (mb.out_valid && !mb.out_ack && !ack_pending) begin
        ack_pending <= 1'b1;
        ack_ptr <= mb.out_ptr;
      end else if (!mb.in_valid && !(evt_pending && !period_done)) begin
        ack_pending <= 1'b0;
      end
    end
  end
endmodule

// file: hw/est_host.sv
// host controller end: apb registers for software, mailbox towards the engine
// assumes an apb master on pclk; answers with no wait state
`timescale 1ns/1ns
module est_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  est_mbox_if.host mb
);
  logic [15:0] cmd_ptr;
  logic [15:0] cmd_data;
  logic [15:0] inbound_mailbox_first;
  logic [15:0] inbound_mailbox_second;
  logic [2:0] int_stat;
  logic [2:0] int_mask;
  logic [2:0] int_set;
  est_pkg::est_cmd_st_t st;
  logic setup;
  logic wr_acc;
  logic rd_stat;
  logic send_req;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_stat = psel & penable & pready & ~pwrite & (paddr == est_pkg::OFS_INT_STAT);
  assign send_req = wr_acc && (paddr == est_pkg::OFS_CTRL) && pwdata[est_pkg::HC_SEND];

  // prdata straight from a flop, loaded in the setup cycle, so no wait state is needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (setup) begin
        case (paddr)
          est_pkg::OFS_CMD_PTR: prdata <= {16'h0000, cmd_ptr};
          est_pkg::OFS_CMD_DATA: prdata <= {16'h0000, cmd_data};
          est_pkg::OFS_CTRL: prdata <= {30'h0, mb.adc_clk_en, mb.engine_en};
          est_pkg::OFS_STATUS: prdata <= {31'h0, st == est_pkg::CMD_WAIT};
          est_pkg::OFS_MB_FIRST: prdata <= {16'h0000, inbound_mailbox_first};
          est_pkg::OFS_MB_SECOND: prdata <= {16'h0000, inbound_mailbox_second};
          est_pkg::OFS_INT_STAT: prdata <= {29'h0, int_stat};
          est_pkg::OFS_INT_MASK: prdata <= {29'h0, int_mask};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ptr <= 16'h0000;
      cmd_data <= 16'h0000;
      int_mask <= 3'h0;
      mb.engine_en <= est_pkg::HCTRL_RST[est_pkg::HC_ENGINE_EN];
      mb.adc_clk_en <= est_pkg::HCTRL_RST[est_pkg::HC_ADC_CLK_EN];
    end else if (wr_acc) begin
      case (paddr)
        est_pkg::OFS_CMD_PTR: cmd_ptr <= pwdata[15:0];
        est_pkg::OFS_CMD_DATA: cmd_data <= pwdata[15:0];
        est_pkg::OFS_CTRL: begin
          mb.engine_en <= pwdata[est_pkg::HC_ENGINE_EN];
          // converter clock stays under software control
          mb.adc_clk_en <= pwdata[est_pkg::HC_ADC_CLK_EN];
        end
        est_pkg::OFS_INT_MASK: int_mask <= pwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // parameters leave only through the outbound mailbox
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= est_pkg::CMD_IDLE;
      mb.out_valid <= 1'b0;
      mb.out_ptr <= 16'h0000;
      mb.out_data <= 16'h0000;
    end else begin
      case (st)
        est_pkg::CMD_IDLE: begin
          if (send_req) begin
            st <= est_pkg::CMD_WAIT;
            mb.out_valid <= 1'b1;
            mb.out_ptr <= cmd_ptr;
            mb.out_data <= cmd_data;
          end
        end
        est_pkg::CMD_WAIT: begin
          if (mb.out_ack) begin
            st <= est_pkg::CMD_IDLE;
            mb.out_valid <= 1'b0;
          end
        end
        default: st <= est_pkg::CMD_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mb.in_ack <= 1'b0;
      inbound_mailbox_first <= 16'h0000;
      inbound_mailbox_second <= 16'h0000;
    end else begin
      mb.in_ack <= mb.in_valid & ~mb.in_ack;
      if (mb.in_valid && !mb.in_ack) begin
        inbound_mailbox_first <= mb.in_first;
        inbound_mailbox_second <= mb.in_second;
      end
    end
  end

  always_comb begin
    int_set = 3'h0;
    if (mb.in_valid && !mb.in_ack) begin
      int_set[est_pkg::INT_EVENT] = (mb.in_first == est_pkg::RET_EVENT);
      int_set[est_pkg::INT_OTHER] = (mb.in_first != est_pkg::RET_EVENT);
    end
    int_set[est_pkg::INT_DONE] = (st == est_pkg::CMD_WAIT) && mb.out_ack;
  end

  // read clears only the bits it returned, so a set after setup survives; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= 3'h0;
      irq <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~(rd_stat ? prdata[2:0] : 3'h0)) | int_set;
      irq <= |(((int_stat & ~(rd_stat ? prdata[2:0] : 3'h0)) | int_set) & int_mask);
    end
  end
endmodule

// file: hw/est_sat_mul.sv
// saturating multiply of a signed sample by a Q2.14 adaptation factor
// assumes purely combinational use inside the engine
`timescale 1ns/1ns
module est_sat_mul (
  input wire logic [15:0] sample,
  input wire logic [15:0] factor,
  output logic [15:0] result
);
  logic signed [31:0] prod;
  logic signed [31:0] shifted;
  assign prod = $signed(sample) * $signed(factor);
  assign shifted = prod >>> est_pkg::ADAPT_FRAC;
  always_comb begin
    if (shifted > $signed({16'h0000, est_pkg::SAMPLE_MAX})) begin
      result = est_pkg::SAMPLE_MAX;
    end else if (shifted < $signed({16'hFFFF, est_pkg::SAMPLE_MIN})) begin
      result = est_pkg::SAMPLE_MIN;
    end else begin
      result = shifted[15:0];
    end
  end
endmodule

// file: inc/est_mbox_if.sv
// mailbox link between the host controller and the metering engine
// assumes both ends share pclk; valid is held until the matching ack pulse
`timescale 1ns/1ns
interface est_mbox_if;
  logic [15:0] out_ptr;
  logic [15:0] out_data;
  logic out_valid;
  logic out_ack;
  logic [15:0] in_first;
  logic [15:0] in_second;
  logic in_valid;
  logic in_ack;
  logic engine_en;
  logic adc_clk_en;
  modport engine (input out_ptr, out_data, out_valid, in_ack, engine_en, adc_clk_en,
                  output out_ack, in_first, in_second, in_valid);
  modport host (output out_ptr, out_data, out_valid, in_ack, engine_en, adc_clk_en,
                input out_ack, in_first, in_second, in_valid);
endinterface

// file: inc/est_pkg.sv
// constants shared by the metering engine, its host controller and the mailbox
// assumes one pclk domain for both ends; adc pins arrive asynchronously
// Functional notes
// - no adc samples means no processing
// - host keeps converter clock enabled while running
// - samples are signed 16-bit, clipped at limits
// - adapt-factor products saturate, never wrap
// - single-current: larger and tamper flags zero
// - engine picks the temperature current channel
// - mode 00 negative: skip, zero, flag
// - mode 01 negative: accumulate absolute, flag
// - mode 10: signed sum, flag, negative factor
// - reversed connection leaves negative energy result in modes 01 and 10
// - larger rms current drives energy calculations
// - larger flag set when second exceeds first
// - tamper flag covers last 4096-sample period
// - tamper ratio Q2.14, from 1.0 below 2.0
// - tamper when larger reaches smaller times ratio
// - both currents below threshold: no tamper
// - host may disable engine after voltage loss
// - parameters reached only through mailbox registers
// - event posts code 0001h and status word
package est_pkg;
  localparam int PERIOD_SAMPLES = 4096;
  localparam logic [11:0] PERIOD_LAST = 12'hFFF;
  localparam logic [15:0] SAMPLE_MAX = 16'h7FFF;
  localparam logic [15:0] SAMPLE_MIN = 16'h8000;
  localparam int ADAPT_FRAC = 14;
  localparam int RATIO_FRAC = 14;
  // parameter pointers carried in the first outbound mailbox
  localparam logic [15:0] PTR_CTRL = 16'h0200;
  localparam logic [15:0] PTR_ADAPT1 = 16'h0210;
  localparam logic [15:0] PTR_ADAPT2 = 16'h0212;
  localparam logic [15:0] PTR_RATIO = 16'h022E;
  localparam logic [15:0] PTR_TAMPER_THRESHOLD_CURRENT = 16'h0230;
  // return codes in the first inbound mailbox
  localparam logic [15:0] RET_EVENT = 16'h0001;
  localparam logic [15:0] RET_PARAM_SET = 16'h0009;
  // engine control word bits
  localparam int CTL_CURR_I2 = 0;
  localparam int CTL_NE_LO = 3;
  localparam int CTL_NE_HI = 4;
  localparam int CTL_EVT_EN = 15;
  localparam logic [1:0] NE_SKIP = 2'b00;
  localparam logic [1:0] NE_ABS = 2'b01;
  localparam logic [1:0] NE_SIGNED = 2'b10;
  // engine status word bits
  localparam int ST_NEG = 0;
  localparam int ST_I2GT = 1;
  localparam int ST_TAMP = 2;
  localparam int ST_TEMP_I2 = 3;
  // reset values of the engine parameters
  localparam logic [15:0] CTRL_RST = 16'h8000;
  localparam logic [15:0] ADAPT_RST = 16'h4000;
  localparam logic [15:0] RATIO_RST = 16'h4000;
  localparam logic [15:0] TAMPER_THRESHOLD_CURRENT_RST = 16'h0000;
  localparam logic [15:0] PF_POS = 16'h7FFF;
  localparam logic [15:0] PF_NEG = 16'h8001;
  // host controller apb offsets
  localparam logic [7:0] OFS_CMD_PTR = 8'h00;
  localparam logic [7:0] OFS_CMD_DATA = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MB_FIRST = 8'h10;
  localparam logic [7:0] OFS_MB_SECOND = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1C;
  localparam int HC_ENGINE_EN = 0;
  localparam int HC_ADC_CLK_EN = 1;
  localparam int HC_SEND = 2;
  localparam int INT_EVENT = 0;
  localparam int INT_OTHER = 1;
  localparam int INT_DONE = 2;
  localparam logic [1:0] HCTRL_RST = 2'b10;
  typedef enum logic [0:0] {CMD_IDLE = 1'b0, CMD_WAIT = 1'b1} est_cmd_st_t;
endpackage

// file: tb/est_checker.sv
// assertions on the mailbox link between the host controller and the engine
// assumes one pclk domain, presetn async active low, placed beside the interface
`timescale 1ns/1ns
module est_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] out_ptr,
  input wire logic [15:0] out_data,
  input wire logic out_valid,
  input wire logic out_ack,
  input wire logic [15:0] in_first,
  input wire logic [15:0] in_second,
  input wire logic in_valid,
  input wire logic in_ack,
  input wire logic engine_en,
  input wire logic adc_clk_en
);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ack_follows_req: assert property ($rose(out_valid) |-> ##[1:40] out_ack)
    else $error("command not acknowledged");
  chk_ack_one_cycle: assert property (out_ack |=> !out_ack)
    else $error("ack longer than one cycle");
  chk_ack_has_req: assert property (out_ack |-> out_valid)
    else $error("ack without command");
  chk_req_dropped: assert property (out_ack |=> !out_valid)
    else $error("command held after ack");
  chk_req_held: assert property (out_valid && !out_ack |=> out_valid && $stable(out_ptr) && $stable(out_data))
    else $error("command changed before ack");
  chk_ret_held: assert property (in_valid && !in_ack |=> in_valid && $stable(in_first) && $stable(in_second))
    else $error("return changed before ack");
  chk_ret_acked: assert property ($rose(in_valid) |=> in_ack)
    else $error("return not acked next cycle");
  chk_ret_dropped: assert property (in_ack |=> !in_valid)
    else $error("return held after ack");
  chk_ret_code: assert property (in_valid |->
    in_first == est_pkg::RET_EVENT || in_first == est_pkg::RET_PARAM_SET)
    else $error("unknown return code");
  chk_reply_after_ack: assert property (out_ack |-> ##[1:40] (in_valid && in_first == est_pkg::RET_PARAM_SET))
    else $error("parameter set not confirmed");
  chk_conv_clock_kept: assert property (engine_en |-> adc_clk_en)
    else $error("converter clock off while running");
  cover property (out_ack);
  cover property (in_valid && in_first == est_pkg::RET_EVENT);
  cover property (in_ack && in_first == est_pkg::RET_PARAM_SET);
endmodule

// file: tb/test_energy_sign_tamper_logic.sv
// bench: apb host controller and metering engine joined by the mailbox
// assumes the bench alone drives apb and adc pins; 4096-sample periods set run time
`timescale 1ns/1ns
module test_energy_sign_tamper_logic;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic adc_valid = 1'b0;
  logic [15:0] adc_v = 16'h0000;
  logic [15:0] adc_i1 = 16'h0000;
  logic [15:0] adc_i2 = 16'h0000;
  logic [47:0] act;
  logic [47:0] tot;
  logic [47:0] tot_b;
  logic [15:0] pf;
  logic [15:0] stw;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int total_checks = 0;
  est_mbox_if u_est_mbox_if ();
  est_host u_est_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .mb(u_est_mbox_if));
  est_engine u_est_engine (.pclk(pclk), .presetn(presetn), .mb(u_est_mbox_if), .adc_valid(adc_valid),
    .adc_v(adc_v), .adc_i1(adc_i1), .adc_i2(adc_i2), .active_energy_result(act), .energy_total(tot),
    .power_factor_result(pf), .engine_status_word(stw));
  est_checker u_est_checker (.pclk(pclk), .presetn(presetn), .out_ptr(u_est_mbox_if.out_ptr),
    .out_data(u_est_mbox_if.out_data), .out_valid(u_est_mbox_if.out_valid), .out_ack(u_est_mbox_if.out_ack),
    .in_first(u_est_mbox_if.in_first), .in_second(u_est_mbox_if.in_second), .in_valid(u_est_mbox_if.in_valid),
    .in_ack(u_est_mbox_if.in_ack), .engine_en(u_est_mbox_if.engine_en), .adc_clk_en(u_est_mbox_if.adc_clk_en));
  initial begin
    forever #50 pclk = ~pclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout();
    n_fail++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    close_out();
  endtask
  // request held until the rising edge that samples pready high; data taken there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    int k;
    for (k = 0; k < 50; k++) begin
      apb(1'b0, a, 32'h00000000);
      if (rd[b] === 1'b1) break;
    end
    if (k == 50) timeout();
  endtask
  task automatic send(input logic [15:0] ptr, input logic [15:0] val);
    apb(1'b1, est_pkg::OFS_CMD_PTR, {16'h0000, ptr});
    apb(1'b1, est_pkg::OFS_CMD_DATA, {16'h0000, val});
    apb(1'b1, est_pkg::OFS_CTRL, 32'h00000007);
  endtask
  task automatic set_param(input logic [15:0] ptr, input logic [15:0] val);
    send(ptr, val);
    poll(est_pkg::OFS_INT_STAT, est_pkg::INT_OTHER);
    rchk(est_pkg::OFS_MB_SECOND, {16'h0000, ptr});
  endtask
  // one sample: data 3 edges before the valid rise and 3 after
  task automatic feed(input int n, input logic [15:0] v, input logic [15:0] i1, input logic [15:0] i2);
    for (int s = 0; s < n; s++) begin
      @(posedge pclk);
      adc_valid <= 1'b0;
      adc_v <= v;
      adc_i1 <= i1;
      adc_i2 <= i2;
      repeat (3) @(posedge pclk);
      adc_valid <= 1'b1;
      repeat (2) @(posedge pclk);
    end
  endtask
  task automatic wait_event();
    int k;
    for (k = 0; k < 100; k++) begin
      @(negedge pclk);
      if (irq === 1'b1) break;
    end
    if (k == 100) timeout();
    rchk(est_pkg::OFS_MB_FIRST, {16'h0000, est_pkg::RET_EVENT});
    rchk(est_pkg::OFS_MB_SECOND, {16'h0000, stw});
    rchk(est_pkg::OFS_INT_STAT, 32'h00000001);
    repeat (2) @(negedge pclk);
    check(irq, 1'b0);
  endtask
  task automatic test_regs();
    check(pf, est_pkg::PF_POS);
    check(stw, 16'h0000);
    check(u_est_mbox_if.adc_clk_en, 1'b1);
    rchk(est_pkg::OFS_CTRL, {30'h0, est_pkg::HCTRL_RST});
    apb(1'b0, 8'h20, 32'h00000000);
    check(err, 1'b1);
    apb(1'b1, est_pkg::OFS_INT_MASK, 32'h00000001);
    send(est_pkg::PTR_CTRL, est_pkg::CTRL_RST);
    poll(est_pkg::OFS_MB_FIRST, 0);
    check(irq, 1'b0);
    rchk(est_pkg::OFS_INT_STAT, 32'h00000006);
    rchk(est_pkg::OFS_MB_FIRST, {16'h0000, est_pkg::RET_PARAM_SET});
    rchk(est_pkg::OFS_MB_SECOND, {16'h0000, est_pkg::PTR_CTRL});
    $display("test regs done");
  endtask
  // single current, skip mode; a stalled converter must hold the period open
  task automatic test_period_count();
    feed(4095, 16'h2000, 16'hF000, 16'h7000);
    repeat (20) @(negedge pclk);
    check(irq, 1'b0);
    feed(1, 16'h2000, 16'hF000, 16'h7000);
    wait_event();
    check(stw[3:0], 4'b1001);
    check(act, 48'h0);
    check(tot, 48'h0);
    $display("test period count done");
  endtask
  // two currents, signed mode; saturated first current keeps its sign
  task automatic test_signed_tamper();
    set_param(est_pkg::PTR_CTRL, 16'h8011);
    set_param(est_pkg::PTR_RATIO, 16'h6000);
    set_param(est_pkg::PTR_ADAPT1, 16'h7FFF);
    feed(4096, 16'h2000, 16'hA000, 16'hF000);
    wait_event();
    check(stw[3:0], 4'b1101);
    check(pf, est_pkg::PF_NEG);
    check(act[47], 1'b1);
    check(tot[47], 1'b1);
    tot_b = tot;
    $display("test signed tamper done");
  endtask
  // absolute mode; both currents under threshold so no tamper
  task automatic test_abs_threshold();
    set_param(est_pkg::PTR_CTRL, 16'h8009);
    set_param(est_pkg::PTR_ADAPT1, est_pkg::ADAPT_RST);
    set_param(est_pkg::PTR_TAMPER_THRESHOLD_CURRENT, 16'h7000);
    feed(4096, 16'h9000, 16'h1000, 16'h2000);
    wait_event();
    check(stw[3:0], 4'b0011);
    check(pf, est_pkg::PF_POS);
    check($signed(tot) > $signed(tot_b), 1'b1);
    check(act[47], 1'b1);
    check(u_est_mbox_if.adc_clk_en, 1'b1);
    $display("test abs threshold done");
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_period_count();
    test_signed_tamper();
    test_abs_threshold();
    close_out();
  end
  initial begin
    repeat (99000) @(posedge pclk);
    timeout();
  end
endmodule
